// File: include/usb_bd_defs.vh
// Purpose: Constants for the buffer-descriptor engine and its register port
// Assumes: Register port addresses are word indices; data is 16 bits wide
// Notes:   Descriptor status field positions, register indices, reset values
`ifndef USB_BD_DEFS_VH
`define USB_BD_DEFS_VH

// Descriptor status word fields
`define BD_OWN_BIT       15
`define BD_TOGGLE_BIT    14
`define BD_PID_HI        13
`define BD_PID_LO        10
`define BD_TSEN_BIT      11
`define BD_STALL_BIT     10
`define BD_COUNT_HI      9

// Register indices on the port (descriptor n: status 2n, address 2n+1)
`define REG_DESC_LAST    6'h07
`define REG_STAT_FLAG    6'h08
`define REG_STAT_EN      6'h09
`define REG_ERR_FLAG     6'h0A
`define REG_ERR_EN       6'h0B
`define REG_CONTROL      6'h0C
`define REG_EP0_CTRL     6'h0D
`define REG_EP_STALL     6'h0E
`define REG_ENGINE       6'h0F

// Field positions in the own registers
`define STAT_ERR_BIT     1
`define STAT_TOKEN_BIT   3
`define STAT_STALL_BIT   7
`define ERR_CRC_BIT      0
`define ERR_OVF_BIT      2
`define CTL_ENABLE_BIT   0
`define CTL_PPRST_BIT    1
`define CTL_HOST_BIT     3
`define EP0_HSHK_BIT     0
`define EP0_RXEN_BIT     3

// Packet identifiers
`define PID_OUT          4'h1
`define PID_IN           4'h9
`define PID_SETUP        4'hD
`define PID_ACK          4'h2
`define PID_NAK          4'hA
`define PID_STALL        4'hE

// Reset values
`define RST_WORD16       16'h0000
`define RST_BYTE         8'h00

`endif

// File: logic/usb_bd_engine.v
// What this block does
// - Owner bit set: engine owns descriptor
// - Owner clear: engine ignores descriptor fields
// - Bit 14 picks DATA1 or DATA0
// - Device role stores received token PID
// - Host role stores returned PID
// - Byte count gives send or receive limit
// - Completion rewrites byte count with actual
// - Toggle sync enable drops wrong toggle
// - Toggle value ignored without sync enable
// - Buffer stall answers STALL, descriptor unchanged
// - Every STALL sets endpoint stall flag
// - All sources share one interrupt output
// - Enabled errors set top error summary
// - Flags clear by writing one only
// - Software can never set a flag
// - Device role handshakes status automatically
// - IN token sends buffer, completes descriptor
// - OUT token stores data, completes descriptor
// - Host role uses endpoint 0 descriptors; the code picks the descriptor by tok_ep in both roles
// - Token done implies owner bit cleared
//
// Purpose: Descriptor-driven transfer engine with write-one-to-clear flags
// Assumes: Packet layer and data memory are synchronous to core_clk
// Notes:   Four descriptors, descriptor n serves endpoint n
`timescale 1ns/1ps
`include "usb_bd_defs.vh"

module usb_bd_engine (
  input  wire        core_clk,     // Module clock, 20 MHz
  input  wire        rst_b,        // Asynchronous reset, active low
  input  wire [5:0]  reg_addr,     // Register word index
  input  wire [15:0] reg_wdata,    // Register write data
  input  wire        reg_wr,       // Register write strobe
  input  wire        reg_rd,       // Register read strobe
  output reg  [15:0] reg_rdata,    // Read data, valid the cycle after reg_rd
  input  wire        tok_valid,    // Token received (device) or issued (host)
  input  wire [3:0]  tok_pid,      // Token packet identifier
  input  wire [1:0]  tok_ep,       // Endpoint addressed by the token
  input  wire        rx_valid,     // Received data byte strobe
  input  wire [7:0]  rx_byte,      // Received data byte
  input  wire        rx_end,       // End of received data packet
  input  wire        rx_toggle,    // Toggle of received data packet
  input  wire        rx_crc_err,   // Received packet failed its check
  input  wire        tx_ready,     // Packet layer took tx_byte
  input  wire        ack_in,       // Far side answered our data packet
  input  wire [3:0]  ret_pid,      // PID the far side returned
  output reg         tx_valid,     // Transmit byte valid
  output reg  [7:0]  tx_byte,      // Transmit byte
  output reg         tx_toggle,    // Toggle of the data packet sent
  output reg         tx_end,       // End of transmitted data packet
  output reg         hs_valid,     // Send a handshake packet
  output reg  [3:0]  hs_pid,       // Handshake to send
  output reg  [15:0] mem_addr,     // Data buffer address
  output reg         mem_rd,       // Data buffer read, data next cycle
  output reg         mem_wr,       // Data buffer write
  output reg  [7:0]  mem_wdata,    // Data buffer write byte
  input  wire [7:0]  mem_rdata,    // Data buffer read byte
  output reg         irq           // Shared interrupt request
);

  // Engine states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RD   = 3'd1;
  localparam [2:0] ST_LOAD = 3'd2;
  localparam [2:0] ST_SEND = 3'd3;
  localparam [2:0] ST_WACK = 3'd4;
  localparam [2:0] ST_RX   = 3'd5;
  localparam [2:0] ST_WB   = 3'd6;

  reg [15:0] desc_stat [0:3];   // Descriptor status words
  reg [15:0] desc_adr  [0:3];   // Descriptor buffer addresses
  reg [7:0]  stat_flag_reg;     // Top-level flags
  reg [7:0]  stat_en_reg;       // Top-level enables
  reg [7:0]  err_flag_reg;      // Error flags
  reg [7:0]  err_en_reg;        // Error enables
  reg [7:0]  control_reg;       // Enable, ping-pong reset, host role
  reg [7:0]  ep0_ctrl_reg;      // Endpoint 0 receive and handshake enable
  reg [3:0]  ep_stall_reg;      // Per-endpoint stall flags
  reg [2:0]  state_reg;         // Engine state
  reg [1:0]  cur_ep_reg;        // Descriptor in use
  reg [3:0]  cur_pid_reg;       // Token of the transfer in flight
  reg [9:0]  count_reg;         // Bytes moved so far
  reg [3:0]  wb_pid_reg;        // PID to write back
  reg        pp_ptr_reg;        // Ping-pong pointer, cleared by software

  // Write-one-to-clear: keep bits not written with one, then add new sets
  function [7:0] w1c;
    input [7:0] cur;
    input [7:0] wr_val;
    input       hit;
    input [7:0] set_bits;
    begin
      w1c = (cur & ~(hit ? wr_val : 8'h00)) | set_bits;
    end
  endfunction

  wire [15:0] cur_desc  = desc_stat[cur_ep_reg];                 // Descriptor in use
  wire [15:0] tok_desc  = desc_stat[tok_ep];                     // Descriptor hit by token
  wire [9:0]  cur_max   = cur_desc[`BD_COUNT_HI:0];
  wire        host_role = control_reg[`CTL_HOST_BIT];
  wire        engine_on = control_reg[`CTL_ENABLE_BIT] & ep0_ctrl_reg[`EP0_RXEN_BIT];
  wire        hshk_en   = ep0_ctrl_reg[`EP0_HSHK_BIT];
  wire        tok_take  = tok_valid & (state_reg == ST_IDLE) & engine_on;
  wire        tok_owned = tok_desc[`BD_OWN_BIT];
  wire        tok_stall = tok_owned & tok_desc[`BD_STALL_BIT];
  wire        tok_go    = tok_take & tok_owned & ~tok_stall;
  // Toggle check only when the descriptor enables it; otherwise the toggle bit is a don't-care
  wire        tog_bad   = cur_desc[`BD_TSEN_BIT] &
                          (rx_toggle != cur_desc[`BD_TOGGLE_BIT]);
  wire        rx_over   = rx_valid & (count_reg == cur_max);
  wire        rx_done   = (state_reg == ST_RX) & rx_end;
  wire        rx_accept = rx_done & ~tog_bad & ~rx_crc_err & ~err_flag_reg[`ERR_OVF_BIT];
  wire        wb_now    = (state_reg == ST_WB);

  // Hardware set terms; software never reaches these
  // Overflow flagged when the extra byte arrives, so it blocks the packet end
  wire [7:0] err_set  = {5'd0, (state_reg == ST_RX) & rx_over, 1'b0, rx_done & rx_crc_err};
  wire       stall_ev = tok_take & tok_stall;
  wire [7:0] stat_set;
  assign stat_set[`STAT_TOKEN_BIT] = wb_now;
  assign stat_set[`STAT_ERR_BIT]   = |(err_flag_reg & err_en_reg);
  assign stat_set[`STAT_STALL_BIT] = stall_ev;
  assign stat_set[0]               = 1'b0;
  assign stat_set[2]               = 1'b0;
  assign stat_set[6:4]             = 3'd0;

  wire wr_stat  = reg_wr & (reg_addr == `REG_STAT_FLAG);
  wire wr_err   = reg_wr & (reg_addr == `REG_ERR_FLAG);
  wire wr_stall = reg_wr & (reg_addr == `REG_EP_STALL);

  // Flag registers: set wins over a same-cycle clear
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_flag_reg <= `RST_BYTE;
      err_flag_reg  <= `RST_BYTE;
      ep_stall_reg  <= 4'h0;
    end else begin
      stat_flag_reg <= w1c(stat_flag_reg, reg_wdata[7:0], wr_stat, stat_set);
      err_flag_reg  <= w1c(err_flag_reg, reg_wdata[7:0], wr_err, err_set);
      ep_stall_reg  <= (ep_stall_reg & ~(wr_stall ? reg_wdata[3:0] : 4'h0))
                       | (stall_ev ? (4'h1 << tok_ep) : 4'h0);
    end
  end

  // Plain control registers and interrupt output
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_en_reg  <= `RST_BYTE;
      err_en_reg   <= `RST_BYTE;
      control_reg  <= `RST_BYTE;
      ep0_ctrl_reg <= `RST_BYTE;
      pp_ptr_reg   <= 1'b0;
      irq          <= 1'b0;
    end else begin
      if (reg_wr) begin
        if (reg_addr == `REG_STAT_EN) begin
          stat_en_reg <= reg_wdata[7:0];
        end else if (reg_addr == `REG_ERR_EN) begin
          err_en_reg <= reg_wdata[7:0];
        end else if (reg_addr == `REG_CONTROL) begin
          control_reg <= reg_wdata[7:0];
        end else if (reg_addr == `REG_EP0_CTRL) begin
          ep0_ctrl_reg <= reg_wdata[7:0];
        end
      end
      // Pointer held at even while the reset bit is high, flips per completion
      if (control_reg[`CTL_PPRST_BIT]) begin
        pp_ptr_reg <= 1'b0;
      end else if (wb_now) begin
        pp_ptr_reg <= ~pp_ptr_reg;
      end
      irq <= |(stat_flag_reg & stat_en_reg);
    end
  end

  // Descriptor storage: CPU writes, engine write-back on completion only
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_desc
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          desc_stat[gi] <= `RST_WORD16;
          desc_adr[gi]  <= `RST_WORD16;
        end else begin
          if (wb_now && cur_ep_reg == gi) begin
            // Owner cleared in the same edge that raises token done
            desc_stat[gi] <= {1'b0, cur_desc[`BD_TOGGLE_BIT],
                              wb_pid_reg, count_reg};
          end else if (reg_wr && reg_addr == (2 * gi)) begin
            desc_stat[gi] <= reg_wdata;
          end
          if (reg_wr && reg_addr == (2 * gi + 1)) begin
            desc_adr[gi] <= reg_wdata;
          end
        end
      end
    end
  endgenerate

  // Register read port: one cycle latency, unmapped reads as zero
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `RST_WORD16;
    end else if (reg_rd) begin
      if (reg_addr <= `REG_DESC_LAST) begin
        reg_rdata <= reg_addr[0] ? desc_adr[reg_addr[2:1]] : desc_stat[reg_addr[2:1]];
      end else if (reg_addr == `REG_STAT_FLAG) begin
        reg_rdata <= {8'h00, stat_flag_reg};
      end else if (reg_addr == `REG_STAT_EN) begin
        reg_rdata <= {8'h00, stat_en_reg};
      end else if (reg_addr == `REG_ERR_FLAG) begin
        reg_rdata <= {8'h00, err_flag_reg};
      end else if (reg_addr == `REG_ERR_EN) begin
        reg_rdata <= {8'h00, err_en_reg};
      end else if (reg_addr == `REG_CONTROL) begin
        reg_rdata <= {8'h00, control_reg};
      end else if (reg_addr == `REG_EP0_CTRL) begin
        reg_rdata <= {8'h00, ep0_ctrl_reg};
      end else if (reg_addr == `REG_EP_STALL) begin
        reg_rdata <= {12'h000, ep_stall_reg};
      end else if (reg_addr == `REG_ENGINE) begin
        reg_rdata <= {4'h0, pp_ptr_reg, state_reg, cur_pid_reg, 2'b00, cur_ep_reg};
      end else begin
        reg_rdata <= `RST_WORD16;
      end
    end
  end

  // Transfer engine
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= ST_IDLE;
      cur_ep_reg  <= 2'd0;
      cur_pid_reg <= 4'h0;
      count_reg   <= 10'd0;
      wb_pid_reg  <= 4'h0;
      tx_valid    <= 1'b0;
      tx_byte     <= `RST_BYTE;
      tx_toggle   <= 1'b0;
      tx_end      <= 1'b0;
      hs_valid    <= 1'b0;
      hs_pid      <= 4'h0;
      mem_addr    <= `RST_WORD16;
      mem_rd      <= 1'b0;
      mem_wr      <= 1'b0;
      mem_wdata   <= `RST_BYTE;
    end else begin
      // Pulses default low
      tx_end   <= 1'b0;
      hs_valid <= 1'b0;
      mem_rd   <= 1'b0;
      mem_wr   <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          count_reg <= 10'd0;
          if (tok_take && !tok_owned) begin
            // CPU still owns it: nothing in the descriptor is looked at
            hs_valid <= hshk_en & ~host_role;
            hs_pid   <= `PID_NAK;
          end else if (stall_ev) begin
            // Descriptor and owner bit left exactly as they were
            hs_valid <= 1'b1;
            hs_pid   <= `PID_STALL;
          end else if (tok_go) begin
            cur_ep_reg  <= tok_ep;
            cur_pid_reg <= tok_pid;
            if (tok_pid == `PID_IN) begin
              state_reg <= ST_RD;
              mem_addr  <= desc_adr[tok_ep];
              mem_rd    <= (tok_desc[`BD_COUNT_HI:0] != 10'd0);
            end else if (tok_pid == `PID_OUT || tok_pid == `PID_SETUP) begin
              state_reg <= ST_RX;
              mem_addr  <= desc_adr[tok_ep];
            end
          end
        end
        ST_RD: begin
          // Zero-length packet skips straight to the packet end
          if (cur_max == 10'd0) begin
            tx_end    <= 1'b1;
            tx_toggle <= cur_desc[`BD_TOGGLE_BIT];
            state_reg <= ST_WACK;
          end else begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          tx_byte   <= mem_rdata;
          tx_valid  <= 1'b1;
          tx_toggle <= cur_desc[`BD_TOGGLE_BIT];
          state_reg <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_ready) begin
            tx_valid  <= 1'b0;
            count_reg <= count_reg + 10'd1;
            if (count_reg + 10'd1 == cur_max) begin
              tx_end    <= 1'b1;
              state_reg <= ST_WACK;
            end else begin
              mem_addr  <= mem_addr + 16'd1;
              mem_rd    <= 1'b1;
              state_reg <= ST_RD;
            end
          end
        end
        ST_WACK: begin
          // Far side's answer closes the transfer; host keeps what came back
          if (ack_in) begin
            wb_pid_reg <= host_role ? ret_pid : cur_pid_reg;
            state_reg  <= ST_WB;
          end
        end
        ST_RX: begin
          // Bytes past the limit are dropped and flagged as each one arrives
          if (rx_valid && !rx_over) begin
            mem_wr    <= 1'b1;
            mem_wdata <= rx_byte;
            mem_addr  <= desc_adr[cur_ep_reg] + {6'd0, count_reg};
            count_reg <= count_reg + 10'd1;
          end
          if (rx_end) begin
            if (rx_accept) begin
              // Status handshake made here, software not involved
              hs_valid   <= hshk_en & ~host_role;
              hs_pid     <= `PID_ACK;
              wb_pid_reg <= host_role ? ret_pid : cur_pid_reg;
              state_reg  <= ST_WB;
            end else begin
              // Bad toggle or bad packet: no answer, descriptor stays owned
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_WB: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // usb_bd_engine

// File: testbench/usb_bd_engine_assertions.sv
// Purpose: Port-level checks of the descriptor engine
// Assumes: One clock domain, reset active low
// Notes:   Only relations visible at the engine's ports
`timescale 1ns/1ps
`include "usb_bd_defs.vh"

module usb_bd_engine_chk (
  input wire        core_clk,   // Module clock
  input wire        rst_b,      // Reset, active low
  input wire [5:0]  reg_addr,   // Register index
  input wire [15:0] reg_wdata,  // Register write data
  input wire        reg_wr,     // Register write strobe
  input wire        tok_valid,  // Token strobe
  input wire        rx_valid,   // Received byte strobe
  input wire [7:0]  rx_byte,    // Received byte
  input wire        rx_end,     // End of received packet
  input wire        rx_crc_err, // Received packet corrupt
  input wire        tx_ready,   // Far side took the byte
  input wire        tx_valid,   // Transmit byte valid
  input wire [7:0]  tx_byte,    // Transmit byte
  input wire        tx_toggle,  // Transmit packet toggle
  input wire        tx_end,     // Transmit packet end
  input wire        hs_valid,   // Handshake strobe
  input wire [3:0]  hs_pid,     // Handshake code
  input wire        mem_wr,     // Buffer write
  input wire [7:0]  mem_wdata,  // Buffer write byte
  input wire        irq         // Shared interrupt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Byte offered but not yet taken
  sequence s_tx_wait;
    tx_valid && !tx_ready;
  endsequence
  // Packet that failed its check
  sequence s_rx_bad;
    rx_end && rx_crc_err;
  endsequence

  AST_HS_PULSE: assert property (hs_valid |=> !hs_valid)
    else $error("handshake longer than one cycle");
  AST_TX_HOLD: assert property (s_tx_wait |=> tx_valid && $stable(tx_byte))
    else $error("transmit byte dropped before taken");
  AST_TOG_HOLD: assert property (s_tx_wait |=> $stable(tx_toggle))
    else $error("toggle changed inside a packet");
  AST_MEM_WR: assert property (mem_wr |-> $past(rx_valid) && mem_wdata == $past(rx_byte))
    else $error("buffer write without matching byte");
  AST_ACK_CAUSE: assert property (hs_valid && hs_pid == `PID_ACK |->
    $past(rx_end) && !$past(rx_crc_err))
    else $error("acknowledge without a good packet");
  AST_BAD_NO_HS: assert property (s_rx_bad |=> !hs_valid)
    else $error("handshake after a corrupt packet");
  AST_HS_CODE: assert property (hs_valid |-> hs_pid inside {`PID_ACK, `PID_NAK, `PID_STALL})
    else $error("unknown handshake code");
  AST_REFUSE_TIME: assert property (hs_valid && hs_pid != `PID_ACK |-> $past(tok_valid))
    else $error("refusal not right after its token");
  AST_IRQ_OFF: assert property (reg_wr && reg_addr == `REG_STAT_EN &&
    reg_wdata == 16'h0000 |-> ##2 !irq)
    else $error("interrupt stays with sources disabled");
  AST_TXEND_GAP: assert property (tx_end |-> !tx_valid)
    else $error("packet end while byte pending");
endmodule // usb_bd_engine_chk

bind usb_bd_engine usb_bd_engine_chk usb_bd_engine_chk_i (
  .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .tok_valid, .rx_valid, .rx_byte,
  .rx_end, .rx_crc_err, .tx_ready, .tx_valid, .tx_byte, .tx_toggle, .tx_end,
  .hs_valid, .hs_pid, .mem_wr, .mem_wdata, .irq);

// File: testbench/usb_host_model.sv
// Purpose: Behavioural bus host facing the engine's packet side
// Assumes: Driven from the bench through its tasks
// Notes:   Byte acceptance can be slowed through slow
`timescale 1ns/1ps
`include "usb_bd_defs.vh"

module usb_host_model (
  input  wire       core_clk,   // Module clock
  output reg        tok_valid,  // Token strobe
  output reg  [3:0] tok_pid,    // Token code
  output reg  [1:0] tok_ep,     // Token endpoint
  output reg        rx_valid,   // Data byte strobe
  output reg  [7:0] rx_byte,    // Data byte
  output reg        rx_end,     // End of data packet
  output reg        rx_toggle,  // Toggle of data packet
  output reg        rx_crc_err, // Packet corrupted on purpose
  output reg        tx_ready,   // Byte taken
  output reg        ack_in,     // Handshake after device data
  output reg  [3:0] ret_pid,    // Handshake code returned
  input  wire       tx_valid,   // Device byte valid
  input  wire [7:0] tx_byte,    // Device byte
  input  wire       tx_toggle,  // Device packet toggle
  input  wire       tx_end      // Device packet end
);
  reg [1:0] slow = 2'd0;        // Wait cycles before taking a byte
  reg [1:0] wcnt = 2'd0;        // Cycles waited on current byte
  reg [7:0] got [0:7];          // Bytes taken from the device
  reg [3:0] n_got = 4'h0;       // Count of bytes taken
  reg       got_tog = 1'b0;     // Toggle seen with the last byte

  initial begin
    {tok_valid, tok_pid, tok_ep, rx_valid, rx_end, rx_toggle, rx_crc_err} = 0;
    {tx_ready, ack_in} = 2'b00;
    rx_byte = 8'h00;
    ret_pid = `PID_ACK;
  end

  // Take device bytes slowly; acknowledge each finished packet
  always @(posedge core_clk) begin
    ack_in   <= tx_end;
    tx_ready <= 1'b0;
    if (tx_valid && !tx_ready) begin
      wcnt <= wcnt + 2'd1;
      if (wcnt == slow) begin
        tx_ready <= 1'b1;
        wcnt     <= 2'd0;
      end
    end
    if (tx_valid && tx_ready) begin
      got[n_got[2:0]] <= tx_byte;
      n_got           <= n_got + 4'h1;
      got_tog         <= tx_toggle;
    end
  end

  // One-cycle token
  task token(input [3:0] p, input [1:0] e);
    begin
      @(posedge core_clk);
      tok_valid <= 1'b1;
      tok_pid   <= p;
      tok_ep    <= e;
      @(posedge core_clk);
      tok_valid <= 1'b0;
    end
  endtask

  // Data packet of n bytes counting up from b; idle byte lines invert
  task data(input [3:0] n, input [7:0] b, input tog, input crc);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_byte  <= b + i[7:0];
      end
      @(posedge core_clk);
      rx_valid   <= 1'b0;
      rx_byte    <= ~rx_byte;
      rx_end     <= 1'b1;
      rx_toggle  <= tog;
      rx_crc_err <= crc;
      @(posedge core_clk);
      rx_end <= 1'b0;
    end
  endtask
endmodule // usb_host_model

// File: testbench/usb_bd_engine_bench.sv
// Purpose: Register-level tests of the descriptor engine
// Assumes: Host model on the packet side, byte memory here
// Notes:   Memory byte k holds k xor A5 at start
`timescale 1ns/1ps
`include "usb_bd_defs.vh"

module usb_bd_engine_bench;
  reg         core_clk  = 1'b0;   // 20 MHz clock
  reg         rst_b     = 1'b0;   // Reset, active low
  reg  [5:0]  reg_addr  = 6'h00;  // Register index
  reg  [15:0] reg_wdata = 16'h0000; // Write data
  reg         reg_wr    = 1'b0;   // Write strobe
  reg         reg_rd    = 1'b0;   // Read strobe
  reg  [7:0]  mem_rdata = 8'h00;  // Memory read byte
  reg  [7:0]  mem [0:63];         // Buffer memory
  reg  [3:0]  last_hs   = 4'h0;   // Last handshake seen
  reg  [3:0]  n_hs      = 4'h0;   // Handshakes seen
  integer     error_cnt = 0;      // Mismatches
  integer     n_compared = 0;     // Comparisons
  integer     k;                  // Loop index
  wire [15:0] reg_rdata, mem_addr;
  wire [7:0]  rx_byte, tx_byte, mem_wdata;
  wire [3:0]  tok_pid, ret_pid, hs_pid;
  wire [1:0]  tok_ep;
  wire        tok_valid, rx_valid, rx_end, rx_toggle, rx_crc_err, tx_ready, ack_in;
  wire        tx_valid, tx_toggle, tx_end, hs_valid, mem_rd, mem_wr, irq;

  usb_bd_engine usb_bd_engine_i (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .tok_valid, .tok_pid, .tok_ep, .rx_valid, .rx_byte, .rx_end,
    .rx_toggle, .rx_crc_err, .tx_ready, .ack_in, .ret_pid, .tx_valid, .tx_byte,
    .tx_toggle, .tx_end, .hs_valid, .hs_pid, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .mem_rdata, .irq);
  usb_host_model usb_host_model_i (.core_clk, .tok_valid, .tok_pid, .tok_ep, .rx_valid,
    .rx_byte, .rx_end, .rx_toggle, .rx_crc_err, .tx_ready, .ack_in, .ret_pid,
    .tx_valid, .tx_byte, .tx_toggle, .tx_end);

  always #25 core_clk = ~core_clk;

  // Memory answers in the cycle after a read strobe
  always @(posedge core_clk) begin
    if (mem_wr) mem[mem_addr[5:0]] <= mem_wdata;
    if (mem_rd) mem_rdata <= mem[mem_addr[5:0]];
    if (hs_valid === 1'b1) begin
      last_hs <= hs_pid;
      n_hs    <= n_hs + 4'h1;
    end
  end

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [5:0] a, input [15:0] d);
    begin
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read
  task rd(input [5:0] a, input [15:0] exp);
    begin
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
    end
  endtask

  task report_and_stop;
    begin
      $display("errors=%0d compared=%0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // Bounded wait for the interrupt; a timeout fails the run
  task wait_irq;
    integer i;
    begin
      for (i = 0; i < 100 && irq !== 1'b1; i = i + 1) @(posedge core_clk);
      if (irq !== 1'b1) begin
        error_cnt = error_cnt + 1;
        report_and_stop;
      end
    end
  endtask

  initial begin
    for (k = 0; k < 64; k = k + 1) mem[k] = k[7:0] ^ 8'hA5;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(6'h00, 16'h0000);
    wr(`REG_CONTROL, 16'h0002);
    wr(`REG_CONTROL, 16'h0000);
    wr(`REG_STAT_EN, 16'h0000);
    wr(`REG_ERR_EN, 16'h0000);
    wr(`REG_STAT_FLAG, 16'h00FF);
    wr(`REG_ERR_FLAG, 16'h00FF);
    rd(`REG_STAT_FLAG, 16'h0000);
    rd(`REG_ERR_FLAG, 16'h0000);
    wr(`REG_CONTROL, 16'h0001);
    wr(`REG_EP0_CTRL, 16'h0009);
    wr(`REG_STAT_EN, 16'h0008);
    rd(6'h3F, 16'h0000);
    // Unowned descriptor is refused
    usb_host_model_i.token(`PID_IN, 2'd0);
    repeat (3) @(posedge core_clk);
    chk(last_hs, `PID_NAK);
    // Stalled descriptor stays untouched
    wr(6'h03, 16'h0000);
    wr(6'h02, 16'h8405);
    usb_host_model_i.token(`PID_OUT, 2'd1);
    repeat (3) @(posedge core_clk);
    chk(last_hs, `PID_STALL);
    rd(6'h02, 16'h8405);
    rd(`REG_EP_STALL, 16'h0002);
    rd(`REG_STAT_FLAG, 16'h0080);
    wr(`REG_EP_STALL, 16'h000F);
    wr(`REG_STAT_FLAG, 16'h0080);
    // IN transfer with a slow host
    usb_host_model_i.slow <= 2'd2;
    wr(6'h05, 16'h0010);
    wr(6'h04, 16'hC003);
    usb_host_model_i.token(`PID_IN, 2'd2);
    wait_irq;
    chk(usb_host_model_i.n_got, 16'h0003);
    for (k = 0; k < 3; k = k + 1) chk(usb_host_model_i.got[k], {8'h00, k[7:0] ^ 8'hB5});
    chk(usb_host_model_i.got_tog, 16'h0001);
    rd(6'h04, 16'h6403);
    rd(`REG_ENGINE, 16'h0892);
    rd(`REG_STAT_FLAG, 16'h0008);
    chk(irq, 16'h0001);
    wr(`REG_STAT_FLAG, 16'h0000);
    rd(`REG_STAT_FLAG, 16'h0008);
    wr(`REG_STAT_FLAG, 16'h0008);
    rd(`REG_STAT_FLAG, 16'h0000);
    chk(irq, 16'h0000);
    // Wrong toggle with sync enabled is ignored
    wr(6'h07, 16'h0020);
    wr(6'h06, 16'h8804);
    usb_host_model_i.token(`PID_OUT, 2'd3);
    usb_host_model_i.data(4'd2, 8'h5A, 1'b1, 1'b0);
    repeat (3) @(posedge core_clk);
    chk(n_hs, 16'h0002);
    rd(6'h06, 16'h8804);
    // Toggle not checked without sync enable
    wr(6'h06, 16'hC004);
    usb_host_model_i.token(`PID_OUT, 2'd3);
    usb_host_model_i.data(4'd2, 8'h6A, 1'b0, 1'b0);
    wait_irq;
    chk(last_hs, `PID_ACK);
    rd(6'h06, 16'h4402);
    chk(mem[32], 16'h006A);
    chk(mem[33], 16'h006B);
    wr(`REG_STAT_FLAG, 16'h0008);
    // Enabled error reaches the summary flag
    wr(`REG_ERR_EN, 16'h0001);
    wr(`REG_STAT_EN, 16'h0002);
    wr(6'h06, 16'h8004);
    usb_host_model_i.token(`PID_OUT, 2'd3);
    usb_host_model_i.data(4'd1, 8'h11, 1'b0, 1'b1);
    repeat (3) @(posedge core_clk);
    chk(n_hs, 16'h0003);
    rd(`REG_ERR_FLAG, 16'h0001);
    rd(`REG_STAT_FLAG, 16'h0002);
    chk(irq, 16'h0001);
    rd(6'h06, 16'h8004);
    wr(`REG_ERR_FLAG, 16'h0001);
    wr(`REG_STAT_FLAG, 16'h0002);
    rd(`REG_STAT_FLAG, 16'h0000);
    // Byte past the limit flags overflow, no answer
    wr(6'h06, 16'h8001);
    usb_host_model_i.token(`PID_OUT, 2'd3);
    usb_host_model_i.data(4'd2, 8'h22, 1'b0, 1'b0);
    repeat (3) @(posedge core_clk);
    rd(`REG_ERR_FLAG, 16'h0004);
    rd(6'h06, 16'h8001);
    // Host role keeps the returned code, sends no handshake
    wr(`REG_STAT_EN, 16'h0008);
    wr(`REG_CONTROL, 16'h0009);
    wr(6'h00, 16'h8000);
    usb_host_model_i.token(`PID_IN, 2'd0);
    wait_irq;
    rd(6'h00, 16'h0800);
    chk(n_hs, 16'h0003);
    wr(`REG_STAT_EN, 16'h0000);
    rd(`REG_STAT_FLAG, 16'h0008);
    chk(irq, 16'h0000);
    report_and_stop;
  end
endmodule // usb_bd_engine_bench
